// *** shared/bssmc_pkg.sv ***
// bssmc_pkg: constants for the buck switching-cycle control block
// assumes a single 200 MHz core clock; all times are turned into cycle counts here
package bssmc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ = 200000;
    localparam int BASE_KHZ = 410;
    localparam int MAX_KHZ = 512;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] BASE_PERIOD = CNT_W'(CLK_KHZ / BASE_KHZ);
    localparam logic [CNT_W-1:0] MIN_PERIOD = CNT_W'(CLK_KHZ / MAX_KHZ);
    localparam logic [CNT_W-1:0] TRIM_MAX = BASE_PERIOD - MIN_PERIOD;
    localparam int BURST_DIV = 4;
    localparam logic [CNT_W-1:0] BURST_PERIOD = CNT_W'(BURST_DIV * (CLK_KHZ / BASE_KHZ));
    localparam logic [1:0] BURST_PULSES = 2'h3;
    localparam logic [2:0] REASSERT_LOW = 3'h3;
    localparam logic [2:0] REASSERT_HIGH = 3'h4;
    localparam int CLK_PS = 5000;
    localparam int MIN_OFF_NS = 200;
    localparam logic [CNT_W-1:0] MIN_OFF_CYC = CNT_W'((MIN_OFF_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam int SYNC_OUTPUT_DLY_NS = 10;
    localparam int SYNC_OUTPUT_DLY_CYC = (SYNC_OUTPUT_DLY_NS * 1000) / CLK_PS;
    localparam int CL_DLY_NS = 39;
    localparam int CL_DLY_CYC = (CL_DLY_NS * 1000) / CLK_PS;
    // a sync edge gap of one slow oscillator period plus the min off-time means the source stopped
    localparam logic [CNT_W-1:0] SYNC_TIMEOUT = BASE_PERIOD + MIN_OFF_CYC;

    // ------------------------------------------------------------------
    // spread-spectrum bins: period in core cycles for 410..467 kHz
    // ------------------------------------------------------------------
    localparam int BIN_W = 3;
    localparam logic [CNT_W-1:0] BIN_PERIOD [8] = '{
        CNT_W'(CLK_KHZ / 410), CNT_W'(CLK_KHZ / 418), CNT_W'(CLK_KHZ / 426),
        CNT_W'(CLK_KHZ / 435), CNT_W'(CLK_KHZ / 443), CNT_W'(CLK_KHZ / 451),
        CNT_W'(CLK_KHZ / 459), CNT_W'(CLK_KHZ / 467)};
    // bin sequence x' = 5x + 3 mod 8 visits each bin once per 8 cycles
    localparam logic [BIN_W-1:0] BIN_MUL = 3'h5;
    localparam logic [BIN_W-1:0] BIN_ADD = 3'h3;

    // ------------------------------------------------------------------
    // synchronised input vector layout
    // ------------------------------------------------------------------
    localparam int TRIM_W = 7;
    localparam int IX_SYNC = 0;
    localparam int IX_PWM = 1;
    localparam int IX_CL = 2;
    localparam int IX_ZC = 3;
    localparam int IX_COMP = 4;
    localparam int IX_SS = 5;
    localparam int IX_DROOP = 6;
    localparam int IX_VLOW = 7;
    localparam int IX_FOLD = 8;
    localparam int IX_OT = 9;
    localparam int IX_SPREAD = 10;
    localparam int IX_TRIM = 11;
    localparam int IN_W = IX_TRIM + TRIM_W;

    // ------------------------------------------------------------------
    // control modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MD_OSC, MD_SYNC, MD_REASSERT, MD_SKIP, MD_BURST, MD_THERMAL
    } bssmc_mode_e;

endpackage : bssmc_pkg

// *** verilog/bssmc_sync.sv ***
// bssmc_sync: two-flop synchroniser for a vector of asynchronous pins
// assumes each bit is an independent level; multi-bit codes are quasi-static
`timescale 1ns/1ps
`default_nettype none
module bssmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [WIDTH-1:0] ASYNC_IN,
    output logic [WIDTH-1:0] SYNC_OUT
);
    initial begin
        if (WIDTH < 1) $error("bssmc_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta_r;
        logic [WIDTH-1:0] stab_r;
    } bssmc_sync_s;

    bssmc_sync_s s_r;
    bssmc_sync_s s_nxt;

    // ------------------------------------------------------------------
    // two stages; only the second stage is read outside
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.meta_r = ASYNC_IN;
        s_nxt.stab_r = s_r.meta_r;
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign SYNC_OUT = s_r.stab_r;
endmodule : bssmc_sync
`default_nettype wire

// *** verilog/bssmc_top.sv ***
// bssmc_top: switching-cycle control for a synchronous buck controller
// assumes analog comparators deliver clean levels; all pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module bssmc_top
    import bssmc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SYNC_INPUT,
    input wire logic PWM_TRIP,
    input wire logic CURRENT_LIMIT,
    input wire logic ZERO_CURRENT,
    input wire logic ERROR_AMP_LOW,
    input wire logic SOFTSTART_ABOVE,
    input wire logic OUTPUT_DROOP,
    input wire logic VIN_LOW,
    input wire logic VIN_FOLDBACK,
    input wire logic OVER_TEMP,
    input wire logic SPREAD_EN,
    input wire logic [TRIM_W-1:0] FREQ_SET_CODE,
    output logic HIGH_SIDE_GATE,
    output logic LOW_SIDE_GATE,
    output logic SYNC_OUTPUT,
    output logic OUTPUT_SINK_EN,
    output logic LOW_IQ_MODE,
    output logic HYSTERETIC_EN,
    output logic SOFTSTART_RESET
);
    // refuse constants that the counters cannot serve
    initial begin
        if (BASE_PERIOD <= MIN_OFF_CYC) $error("bssmc_top: period shorter than min off");
        if (SYNC_OUTPUT_DLY_CYC > 3 || CL_DLY_CYC < 3) $error("bssmc_top: pipeline too long");
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // base period from the trim code, clamped so the base rate stays at 512 kHz or below; faster spread bins still scale past it
    // an unclamped large code would shorten the period past 512 kHz
    function automatic logic [CNT_W-1:0] base_from_trim(input logic [TRIM_W-1:0] code);
        logic [CNT_W-1:0] t;
        t = CNT_W'(code);
        if (t > TRIM_MAX) begin
            t = TRIM_MAX;
        end
        return BASE_PERIOD - t;
    endfunction : base_from_trim

    // bin period scaled by the trimmed base period
    // double-width product: 487 x 487 does not fit twelve bits
    function automatic logic [CNT_W-1:0] bin_period(input logic [BIN_W-1:0] bin,
                                                    input logic [CNT_W-1:0] base);
        logic [2*CNT_W-1:0] p;
        p = (2*CNT_W)'(BIN_PERIOD[bin]) * (2*CNT_W)'(base);
        return CNT_W'(p / (2*CNT_W)'(BASE_PERIOD));
    endfunction : bin_period

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // all comparator pins are asynchronous to the core clock
    // trim code is quasi-static, so skew between its bits is harmless
    logic [IN_W-1:0] pins_async;
    logic [IN_W-1:0] pins;

    assign pins_async = {FREQ_SET_CODE, SPREAD_EN, OVER_TEMP, VIN_FOLDBACK, VIN_LOW,
                         OUTPUT_DROOP, SOFTSTART_ABOVE, ERROR_AMP_LOW, ZERO_CURRENT,
                         CURRENT_LIMIT, PWM_TRIP, SYNC_INPUT};

    bssmc_sync #(.WIDTH(IN_W)) u_sync (
        .CLOCK(CLOCK),
        .RST(RST),
        .ASYNC_IN(pins_async),
        .SYNC_OUT(pins)
    );

    logic sync_lvl;
    logic ot;
    logic comp_low;
    assign sync_lvl = pins[IX_SYNC];
    assign ot = pins[IX_OT];
    assign comp_low = pins[IX_COMP];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // one packed record; its next value is built in one process
    typedef struct packed {
        bssmc_mode_e mode;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] gap;
        logic [CNT_W-1:0] fix_cnt;
        logic [CNT_W-1:0] period;
        logic [2:0] reps;
        logic [BIN_W-1:0] bin;
        logic sync_d;
        logic ss_done;
        logic gh;
        logic gl;
        logic sync_output;
        logic sink;
        logic low_iq;
        logic hyst;
        logic ss_rst;
    } bssmc_state_s;

    bssmc_state_s s_r;
    bssmc_state_s s_nxt;

    logic sync_rise;
    logic de_mode;
    logic start;

    // mode flow, one step per core cycle:
    //   oscillator -> sync on the first sync rising edge
    //   sync -> takeover once no rising edge comes within the timeout
    //   takeover -> oscillator after three or four base periods
    //   oscillator, sync or burst -> skip while the error amp sits low
    //   skip -> burst of quarter-rate pulses -> oscillator
    //   thermal overrides every mode and leaves to the oscillator
    // gates: a start raises the high gate, a trip swaps to the low gate
    // takeover, skip and thermal keep the high gate off
    // a start never raises the high gate into a live current limit
    // the low gate drops on zero current only in diode emulation
    // the bin advances only at a start, so no period is cut short

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        start = 1'b0;
        sync_rise = sync_lvl & ~s_r.sync_d;
        // open or grounded sync pin with no clock on it
        de_mode = ~sync_lvl && (s_r.mode != MD_SYNC);
        s_nxt.sync_d = sync_lvl;
        if (s_r.cnt != '1) begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
        if (s_r.gap != '1) begin
            s_nxt.gap = s_r.gap + CNT_W'(1);
        end
        if (sync_rise) begin
            s_nxt.gap = '0;
        end

        // high gate ends on PWM trip, current limit or min off-time
        // a start in the same cycle wins over a trip
        if (s_r.gh && (pins[IX_PWM] || pins[IX_CL] ||
                s_r.cnt >= s_r.period - MIN_OFF_CYC)) begin
            s_nxt.gh = 1'b0;
            s_nxt.gl = 1'b1;
        end
        // block reverse inductor current in diode emulation
        if (de_mode && pins[IX_ZC] && !s_r.gh) begin
            s_nxt.gl = 1'b0;
        end

        case (s_r.mode)
            MD_OSC: begin
                if (comp_low) begin
                    s_nxt.mode = MD_SKIP;
                end else if (sync_rise) begin
                    s_nxt.mode = MD_SYNC;
                    start = 1'b1;
                end else if (s_r.cnt >= s_r.period - CNT_W'(1)) begin
                    start = 1'b1;
                end
            end
            MD_SYNC: begin
                if (comp_low) begin
                    s_nxt.mode = MD_SKIP;
                end else if (sync_rise) begin
                    start = 1'b1;
                end else if (s_r.gap >= SYNC_TIMEOUT) begin
                    s_nxt.mode = MD_REASSERT;
                    s_nxt.cnt = '0;
                    s_nxt.reps = sync_lvl ? REASSERT_HIGH : REASSERT_LOW;
                end
            end
            // takeover: gates held, base periods counted down
            MD_REASSERT: begin
                s_nxt.gh = 1'b0;
                s_nxt.gl = 1'b1;
                if (sync_rise) begin
                    s_nxt.mode = MD_SYNC;
                    start = 1'b1;
                end else if (s_r.cnt >= BASE_PERIOD - CNT_W'(1)) begin
                    s_nxt.cnt = '0;
                    s_nxt.reps = s_r.reps - 3'h1;
                    if (s_r.reps == 3'h1) begin
                        s_nxt.mode = MD_OSC;
                        start = 1'b1;
                    end
                end
            end
            // skip: gates off, oscillator asleep
            MD_SKIP: begin
                s_nxt.gh = 1'b0;
                s_nxt.gl = 1'b0;
                if (!comp_low) begin
                    s_nxt.mode = MD_BURST;
                    s_nxt.reps = 3'(BURST_PULSES);
                    start = 1'b1;
                end
            end
            // burst: quarter-rate pulses, then oscillator
            MD_BURST: begin
                if (comp_low) begin
                    s_nxt.mode = MD_SKIP;
                end else if (s_r.cnt >= s_r.period - CNT_W'(1)) begin
                    s_nxt.reps = s_r.reps - 3'h1;
                    if (s_r.reps == 3'h1) begin
                        s_nxt.mode = MD_OSC;
                    end
                    start = 1'b1;
                end
            end
            // thermal: gates off until the pin clears
            MD_THERMAL: begin
                s_nxt.gh = 1'b0;
                s_nxt.gl = 1'b0;
                if (!ot) begin
                    s_nxt.mode = MD_OSC;
                    s_nxt.cnt = '0;
                end
            end
            default: begin
                s_nxt.mode = MD_OSC;
            end
        endcase

        // cycle boundary: launch high gate and take the next period
        if (start) begin
            s_nxt.cnt = '0;
            s_nxt.gh = !pins[IX_CL];
            s_nxt.gl = 1'b0;
            if (s_r.mode == MD_SKIP || s_nxt.mode == MD_BURST) begin
                s_nxt.period = BURST_PERIOD;
            end else if (s_nxt.mode == MD_SYNC) begin
                s_nxt.period = base_from_trim(pins[IX_TRIM +: TRIM_W]);
            end else begin
                s_nxt.period = bin_period(pins[IX_SPREAD] ? s_r.bin : '0,
                                          base_from_trim(pins[IX_TRIM +: TRIM_W]));
                // bin steps only at a cycle start
                if (pins[IX_SPREAD]) begin
                    s_nxt.bin = BIN_W'(s_r.bin * BIN_MUL + BIN_ADD);
                end
            end
        end

        // skip stops both gates at once, whatever started this cycle
        if (s_nxt.mode == MD_SKIP) begin
            s_nxt.gh = 1'b0;
            s_nxt.gl = 1'b0;
        end

        // over-temperature overrides the mode and both gates and restarts soft-start
        if (ot) begin
            s_nxt.mode = MD_THERMAL;
            s_nxt.gh = 1'b0;
            s_nxt.gl = 1'b0;
            s_nxt.ss_done = 1'b0;
        end else if (pins[IX_SS]) begin
            s_nxt.ss_done = 1'b1;
        end
        s_nxt.ss_rst = ot;

        // fixed 410 kHz reference for the current-limit case
        // free running, so it never follows the spread bin
        if (s_r.fix_cnt >= BASE_PERIOD - CNT_W'(1)) begin
            s_nxt.fix_cnt = '0;
        end else begin
            s_nxt.fix_cnt = s_r.fix_cnt + CNT_W'(1);
        end

        // sync output source selection
        // follows the coming mode, so silence starts with low_iq
        if (!s_r.ss_done || s_nxt.mode == MD_SKIP || s_nxt.mode == MD_THERMAL) begin
            s_nxt.sync_output = 1'b0;
        end else if (pins[IX_CL] && pins[IX_DROOP]) begin
            s_nxt.sync_output = s_r.fix_cnt < (BASE_PERIOD >> 1);
        end else if (s_r.mode == MD_SYNC) begin
            s_nxt.sync_output = sync_lvl;
        end else begin
            s_nxt.sync_output = s_r.cnt < (s_r.period >> 1);
        end

        // status pins registered; low_iq and hyst from the coming mode, sink from the current mode
        s_nxt.sink = sync_lvl || (s_r.mode == MD_SYNC) ||
                     pins[IX_VLOW] || pins[IX_FOLD];
        s_nxt.low_iq = (s_nxt.mode == MD_SKIP);
        s_nxt.hyst = (s_nxt.mode == MD_SKIP) && de_mode;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // reset lands in oscillator mode at the base period
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s_r <= '{mode: MD_OSC, period: BASE_PERIOD, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------------
    assign HIGH_SIDE_GATE = s_r.gh;
    assign LOW_SIDE_GATE = s_r.gl;
    assign SYNC_OUTPUT = s_r.sync_output;
    assign OUTPUT_SINK_EN = s_r.sink;
    assign LOW_IQ_MODE = s_r.low_iq;
    assign HYSTERETIC_EN = s_r.hyst;
    assign SOFTSTART_RESET = s_r.ss_rst;
endmodule : bssmc_top
`default_nettype wire

// *** bench/bssmc_checker.sv ***
// bssmc_checker: port-level timing assertions for bssmc_top
// assumes bound into bssmc_top; one core clock domain, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module bssmc_checker
    import bssmc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SYNC_INPUT,
    input wire logic PWM_TRIP,
    input wire logic CURRENT_LIMIT,
    input wire logic ZERO_CURRENT,
    input wire logic ERROR_AMP_LOW,
    input wire logic SOFTSTART_ABOVE,
    input wire logic OUTPUT_DROOP,
    input wire logic VIN_LOW,
    input wire logic VIN_FOLDBACK,
    input wire logic OVER_TEMP,
    input wire logic SPREAD_EN,
    input wire logic [TRIM_W-1:0] FREQ_SET_CODE,
    input wire logic HIGH_SIDE_GATE,
    input wire logic LOW_SIDE_GATE,
    input wire logic SYNC_OUTPUT,
    input wire logic OUTPUT_SINK_EN,
    input wire logic LOW_IQ_MODE,
    input wire logic HYSTERETIC_EN,
    input wire logic SOFTSTART_RESET
);
    typedef struct packed {
        logic sync_q;
        logic seen;
        logic [11:0] since;
    } bssmc_chk_s;
    bssmc_chk_s st_r;
    bssmc_chk_s st_nxt;
    logic idle_w;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // cycles since the last sync rising edge, saturating
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync_q = SYNC_INPUT;
        if (SYNC_INPUT && !st_r.sync_q) begin
            st_nxt.seen = 1'b1;
            st_nxt.since = 12'h000;
        end else if (st_r.since != 12'hFFF) begin
            st_nxt.since = st_r.since + 12'h001;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (RST) st_r <= '0;
        else st_r <= st_nxt;
    end
    // well clear of any takeover window
    assign idle_w = !st_r.seen || st_r.since > 12'hA28;
    // quiet conditions under which sync output mirrors the pin
    sequence s_settled;
        (SOFTSTART_ABOVE && !ERROR_AMP_LOW && !OVER_TEMP && !CURRENT_LIMIT)[*8];
    endsequence
    sequence s_lost;
        st_r.seen && (st_r.since == 12'h21C || st_r.since == 12'h7A8);
    endsequence
    thermal_stop_a: assert property (OVER_TEMP[*4] |->
        SOFTSTART_RESET && !HIGH_SIDE_GATE && !LOW_SIDE_GATE) else $error("thermal stop");
    skip_quiet_a: assert property ((ERROR_AMP_LOW && !OVER_TEMP)[*4] |->
        LOW_IQ_MODE && !SYNC_OUTPUT) else $error("pulse skip not quiet");
    hyst_in_skip_a: assert property (HYSTERETIC_EN |->
        LOW_IQ_MODE && !HIGH_SIDE_GATE) else $error("hysteretic outside skip");
    sync_rise_a: assert property (s_settled ##0 $rose(SYNC_INPUT) |-> ##3 SYNC_OUTPUT)
        else $error("sync output rise late");
    sync_fall_a: assert property (s_settled ##0 $fell(SYNC_INPUT) |-> ##3 !SYNC_OUTPUT)
        else $error("sync output fall late");
    takeover_hold_a: assert property (s_lost ##0 (!OVER_TEMP && !ERROR_AMP_LOW) |->
        !HIGH_SIDE_GATE && LOW_SIDE_GATE) else $error("takeover gates wrong");
    limit_cut_a: assert property (CURRENT_LIMIT[*3] |=> !HIGH_SIDE_GATE)
        else $error("current limit missed");
    sink_on_a: assert property ((SYNC_INPUT || VIN_LOW || VIN_FOLDBACK)[*4] |->
        OUTPUT_SINK_EN) else $error("sense sink off");
    gate_excl_a: assert property (!(HIGH_SIDE_GATE && LOW_SIDE_GATE))
        else $error("both gates on");
    zero_cut_a: assert property ((ZERO_CURRENT && !SYNC_INPUT && !HIGH_SIDE_GATE && idle_w)[*4]
        |-> !LOW_SIDE_GATE) else $error("low gate kept on");
endmodule : bssmc_checker
bind bssmc_top bssmc_checker i_chk (
    .CLOCK(CLOCK), .RST(RST), .SYNC_INPUT(SYNC_INPUT), .PWM_TRIP(PWM_TRIP),
    .CURRENT_LIMIT(CURRENT_LIMIT), .ZERO_CURRENT(ZERO_CURRENT), .ERROR_AMP_LOW(ERROR_AMP_LOW),
    .SOFTSTART_ABOVE(SOFTSTART_ABOVE), .OUTPUT_DROOP(OUTPUT_DROOP), .VIN_LOW(VIN_LOW),
    .VIN_FOLDBACK(VIN_FOLDBACK), .OVER_TEMP(OVER_TEMP), .SPREAD_EN(SPREAD_EN),
    .FREQ_SET_CODE(FREQ_SET_CODE), .HIGH_SIDE_GATE(HIGH_SIDE_GATE),
    .LOW_SIDE_GATE(LOW_SIDE_GATE), .SYNC_OUTPUT(SYNC_OUTPUT), .OUTPUT_SINK_EN(OUTPUT_SINK_EN),
    .LOW_IQ_MODE(LOW_IQ_MODE), .HYSTERETIC_EN(HYSTERETIC_EN), .SOFTSTART_RESET(SOFTSTART_RESET)
);
`default_nettype wire

// *** bench/bssmc_sync_source.sv ***
// bssmc_sync_source: external clock source driving the sync input pin
// assumes the bench starts and stops frames; line parks at the chosen level
`timescale 1ns/1ps
`default_nettype none
module bssmc_sync_source (
    input wire logic RUN,
    input wire logic SLOW,
    input wire logic STOP_HIGH,
    output logic SYNC_OUT
);
    real half;
    // one full period per pass while running, otherwise hold still
    always begin
        if (RUN) begin
            half = SLOW ? 1000.0 : 62.5;
            SYNC_OUT = 1'b1;
            #(half);
            if (RUN || !STOP_HIGH) SYNC_OUT = 1'b0;
            #(half);
        end else begin
            if (STOP_HIGH !== 1'b1) SYNC_OUT = 1'b0;
            #1;
        end
    end
endmodule : bssmc_sync_source
`default_nettype wire

// *** bench/test_buck_sync_spread_mode_control.sv ***
// test_buck_sync_spread_mode_control: self-checking bench for bssmc_top
// assumes bssmc_sync_source on the sync pin and the checker bound in
`timescale 1ns/1ps
`default_nettype none
module test_buck_sync_spread_mode_control;
    import bssmc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sync_in, pwm_trip, cur_lim, zero_cur, ea_low, ss_above, droop, vin_low;
    logic vin_fold, over_temp, spread_en, src_run, src_slow, src_high;
    logic [TRIM_W-1:0] trim;
    logic gh, gl, sync_out, sink_en, low_iq, hyst_en, ss_reset;
    logic gh_q = 1'b0;
    logic pwm_pin = 1'b0;
    logic auto_trip = 1'b0;
    int cyc = 0;
    int t_rise = 0;
    int n_rise = 0;
    int gap = 0;
    int miscompares = 0;
    int tests_run = 0;
    int g;
    localparam int LIMIT = 60000;
    localparam int FREQ [8] = '{410, 418, 426, 435, 443, 451, 459, 467};
    localparam logic [6:0] CODES [4] = '{7'h00, 7'h28, 7'h61, 7'h7F};
    always #2.5 clock = ~clock;
    bssmc_sync_source i_src (.RUN(src_run), .SLOW(src_slow), .STOP_HIGH(src_high),
        .SYNC_OUT(sync_in));
    // far-side PWM comparator: trips on the high gate when enabled
    always @(negedge clock) pwm_pin <= pwm_trip || (auto_trip && gh === 1'b1);
    bssmc_top i_dut (.CLOCK(clock), .RST(rst), .SYNC_INPUT(sync_in), .PWM_TRIP(pwm_pin),
        .CURRENT_LIMIT(cur_lim), .ZERO_CURRENT(zero_cur), .ERROR_AMP_LOW(ea_low),
        .SOFTSTART_ABOVE(ss_above), .OUTPUT_DROOP(droop), .VIN_LOW(vin_low),
        .VIN_FOLDBACK(vin_fold), .OVER_TEMP(over_temp), .SPREAD_EN(spread_en),
        .FREQ_SET_CODE(trim), .HIGH_SIDE_GATE(gh), .LOW_SIDE_GATE(gl), .SYNC_OUTPUT(sync_out),
        .OUTPUT_SINK_EN(sink_en), .LOW_IQ_MODE(low_iq), .HYSTERETIC_EN(hyst_en),
        .SOFTSTART_RESET(ss_reset));
    // high gate rise spacing and run ceiling
    always @(posedge clock) begin
        cyc <= cyc + 1;
        gh_q <= gh;
        if (gh === 1'b1 && gh_q === 1'b0) begin
            n_rise <= n_rise + 1;
            gap <= cyc - t_rise;
            t_rise <= cyc;
        end
        if (cyc == LIMIT) begin
            miscompares = miscompares + 1;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask : cycles
    task automatic next_gap(output int d);
        int n;
        n = n_rise;
        wait (n_rise != n);
        @(negedge clock);
        d = gap;
    endtask : next_gap
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (sync_out === lvl) begin
            n++;
            @(negedge clock);
        end
    endtask : run_len
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_sink();
        vin_low = 1'b1;
        cycles(5);
        chk(16'(sink_en), 16'h0001);
        vin_low = 1'b0;
        vin_fold = 1'b1;
        cycles(5);
        chk(16'(sink_en), 16'h0001);
        vin_fold = 1'b0;
        cycles(5);
        chk(16'(sink_en), 16'h0000);
    endtask : t_sink
    task automatic t_trim();
        foreach (CODES[i]) begin
            trim = CODES[i];
            next_gap(g);
            pwm_trip = 1'b1;
            cycles(4);
            pwm_trip = 1'b0;
            next_gap(g);
            next_gap(g);
            chk(16'(g), 16'(BASE_PERIOD - ((CODES[i] > TRIM_MAX) ? TRIM_MAX : CODES[i])));
        end
        trim = 7'h00;
    endtask : t_trim
    task automatic t_spread();
        logic [7:0] hit;
        hit = 8'h00;
        spread_en = 1'b1;
        next_gap(g);
        next_gap(g);
        repeat (8) begin
            next_gap(g);
            foreach (FREQ[j]) if (g == CLK_KHZ / FREQ[j]) hit[j] = 1'b1;
        end
        chk(16'(hit), 16'h00FF);
        spread_en = 1'b0;
    endtask : t_spread
    task automatic t_limit();
        next_gap(g);
        ss_above = 1'b1;
        cur_lim = 1'b1;
        cycles(4);
        chk(16'(gh), 16'h0000);
        droop = 1'b1;
        zero_cur = 1'b1;
        cycles(6);
        chk(16'(gl), 16'h0000);
        run_len(1'b1, g);
        run_len(1'b0, g);
        run_len(1'b1, g);
        chk(16'(g), 16'h00F3);
        run_len(1'b0, g);
        chk(16'(g), 16'h00F4);
        {cur_lim, droop, zero_cur} = '0;
    endtask : t_limit
    task automatic t_thermal();
        over_temp = 1'b1;
        ss_above = 1'b0;
        cycles(10);
        chk(16'(ss_reset), 16'h0001);
        over_temp = 1'b0;
        next_gap(g);
        chk(16'(ss_reset), 16'h0000);
    endtask : t_thermal
    task automatic t_skip();
        ea_low = 1'b1;
        cycles(10);
        chk(16'(low_iq), 16'h0001);
        chk(16'(hyst_en), 16'h0001);
        chk(16'(gh), 16'h0000);
        ea_low = 1'b0;
        next_gap(g);
        next_gap(g);
        chk(16'(g), 16'(BURST_PERIOD));
        next_gap(g);
        chk(16'(g), 16'(BURST_PERIOD));
    endtask : t_skip
    task automatic t_sync(input logic slow, input logic high, input int lo, input int hi);
        auto_trip = 1'b1;
        ss_above = 1'b0;
        over_temp = 1'b1; // fresh soft-start event
        cycles(5);
        over_temp = 1'b0;
        src_slow = slow;
        src_high = high;
        src_run = 1'b1;
        next_gap(g);
        next_gap(g);
        chk(16'(sync_out), 16'h0000);
        ss_above = 1'b1;
        repeat (4) next_gap(g);
        chk(16'(sync_out), 16'h0001);
        chk(16'(g), slow ? 16'h0190 : 16'h0019);
        src_run = 1'b0;
        next_gap(g);
        chk(16'(g >= lo && g <= hi), 16'h0001);
    endtask : t_sync
    initial begin
        {pwm_trip, cur_lim, zero_cur, ea_low, ss_above, droop, vin_low} = '0;
        {vin_fold, over_temp, spread_en, src_run, src_slow, src_high} = '0;
        trim = 7'h00;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        t_sink();
        t_trim();
        t_spread();
        t_limit();
        t_thermal();
        t_skip();
        t_sync(1'b1, 1'b0, 1984, 2000);
        t_sync(1'b0, 1'b1, 2471, 2515);
        end_of_test();
    end
endmodule : test_buck_sync_spread_mode_control
`default_nettype wire
